/* rtl/smsr_map.vh */
// Register map, field positions and reset values of the synchronous master receiver
//
// Behaviour
// - Reception starts only with single or continuous enable
// - Sample data on falling strobe edge
// - Single enable alone receives exactly one word
// - Continuous enable receives until software clears it
// - Both set behaves as continuous reception
// - Clearing continuous enable clears receive errors
// - Polarity invert bit inverts driven strobe
// - Ninth bit enable gives 9-bit words
// - Word done sets flag; interrupt if enabled
// - Ninth bit and error flags in status
// - Low eight bits readable in data register
// - Data pin and strobe pin in synchronous mode
`ifndef SMSR_MAP_VH
`define SMSR_MAP_VH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define SMSR_OFS_INTCTL    8'h00
`define SMSR_OFS_PFLAGS    8'h04
`define SMSR_OFS_PENABLE   8'h08
`define SMSR_OFS_PPRIO     8'h0C
`define SMSR_OFS_RSTAT     8'h10
`define SMSR_OFS_RDATA     8'h14
`define SMSR_OFS_TSTAT     8'h18
`define SMSR_OFS_BAUDCTL   8'h1C
`define SMSR_OFS_DIVHI     8'h20
`define SMSR_OFS_DIVLO     8'h24
`define SMSR_OFS_IRQSTAT   8'h28
`define SMSR_OFS_IRQMASK   8'h2C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMSR_INT_GIE       7
`define SMSR_INT_PERIPHERAL_INT_ENABLE      6
`define SMSR_PF_RXFLAG     5
`define SMSR_RS_SERIAL_PORT_ENABLE       7
`define SMSR_RS_RX9        6
`define SMSR_RS_SINGLE_RECEIVE_ENABLE       5
`define SMSR_RS_CONTINUOUS_RECEIVE_ENABLE       4
`define SMSR_RS_FRAMING_ERROR_FLAG       2
`define SMSR_RS_OVERRUN_ERROR_FLAG       1
`define SMSR_RS_RECEIVED_NINTH_BIT       0
`define SMSR_TS_STROBE_SOURCE_SELECT       7
`define SMSR_TS_SYNC       4
`define SMSR_TS_HIGH_BAUD_SELECT       2
`define SMSR_BC_IDLE       6
`define SMSR_BC_INV        4
`define SMSR_BC_WIDE       3
`define SMSR_IRQ_WORD      0
`define SMSR_IRQ_OVR       1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SMSR_RST_BYTE      8'h00
`define SMSR_RST_IRQ       2'h0

`endif

/* rtl/smsr_receiver.v */
// Synchronous master serial receiver with AXI4-Lite register slave
`timescale 1ns/100ps
`include "smsr_map.vh"

module smsr_receiver
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        serial_data_pin_in,
    output wire        serial_data_pin_out,
    output wire        serial_data_pin_oe,
    input  wire        serial_shift_strobe_pin_in,
    output reg         serial_shift_strobe_pin_out,
    output reg         serial_shift_strobe_pin_oe,
    output wire        irq,
    output wire        cpu_irq
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg  [7:0]  interrupt_control;
reg  [7:0]  peripheral_enables_one;
reg  [7:0]  peripheral_priorities_one;
reg  [7:0]  receive_data_reg;
reg  [7:0]  transmit_status_control;
reg  [7:0]  baud_control;
reg  [7:0]  baud_divisor_high;
reg  [7:0]  baud_divisor_low;
reg         serial_port_enable;
reg         ninth_bit_receive_enable;
reg         single_receive_enable;
reg         continuous_receive_enable;
reg         framing_error_flag;
reg         overrun_error_flag;
reg         received_ninth_bit;
reg         receive_flag;
reg  [1:0]  irq_status;
reg  [1:0]  irq_mask;
reg         rx_active;

// ----------------------------------------
// Bus slave
// ----------------------------------------
reg         aw_held;
reg  [7:0]  aw_addr;
reg         w_held;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
wire        do_write;
wire        do_read;
wire        rdata_read;
wire        rstat_read;
wire        irq_read;
reg  [31:0] next_rdata;
reg  [1:0]  next_rresp;

assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready  = !w_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
assign do_write      = aw_held && w_held && !s_axi_bvalid;
assign do_read       = s_axi_arvalid && !s_axi_rvalid;
assign rdata_read    = do_read && (s_axi_araddr == `SMSR_OFS_RDATA);
assign rstat_read    = do_read && (s_axi_araddr == `SMSR_OFS_RSTAT);
assign irq_read      = do_read && (s_axi_araddr == `SMSR_OFS_IRQSTAT);

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        aw_addr      <= 8'h00;
        w_data       <= 32'h00000000;
        w_strb       <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= 2'h0;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr > `SMSR_OFS_IRQMASK || aw_addr[1:0] != 2'h0) ?
                            2'h2 : 2'h0;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
end

always @*
begin
    next_rresp = 2'h0;
    case (s_axi_araddr)
        `SMSR_OFS_INTCTL:  next_rdata = {24'h000000, interrupt_control};
        `SMSR_OFS_PFLAGS:  next_rdata = {26'h0000000, receive_flag, 5'h00};
        `SMSR_OFS_PENABLE: next_rdata = {24'h000000, peripheral_enables_one};
        `SMSR_OFS_PPRIO:   next_rdata = {24'h000000, peripheral_priorities_one};
        // Error and ninth bit sit here so one read shows them before the data
        `SMSR_OFS_RSTAT:   next_rdata = {24'h000000, serial_port_enable,
                               ninth_bit_receive_enable, single_receive_enable,
                               continuous_receive_enable, 1'b0, framing_error_flag,
                               overrun_error_flag, received_ninth_bit};
        `SMSR_OFS_RDATA:   next_rdata = {24'h000000, receive_data_reg};
        `SMSR_OFS_TSTAT:   next_rdata = {24'h000000, transmit_status_control};
        `SMSR_OFS_BAUDCTL: next_rdata = {24'h000000, baud_control[7],
                               !rx_active, baud_control[5:0]};
        `SMSR_OFS_DIVHI:   next_rdata = {24'h000000, baud_divisor_high};
        `SMSR_OFS_DIVLO:   next_rdata = {24'h000000, baud_divisor_low};
        `SMSR_OFS_IRQSTAT: next_rdata = {30'h00000000, irq_status};
        `SMSR_OFS_IRQMASK: next_rdata = {30'h00000000, irq_mask};
        default:
        begin
            next_rdata = 32'h00000000;
            next_rresp = 2'h2;
        end
    endcase
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h00000000;
        s_axi_rresp  <= 2'h0;
    end
    else if (do_read)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rresp;
    end
    else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
end

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg  [1:0]  data_sync;
reg  [1:0]  strobe_sync;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        data_sync   <= 2'h0;
        strobe_sync <= 2'h0;
    end
    else
    begin
        data_sync   <= {data_sync[0], serial_data_pin_in};
        strobe_sync <= {strobe_sync[0], serial_shift_strobe_pin_in};
    end
end

// Receive only: the data pin is never driven
assign serial_data_pin_out = 1'b0;
assign serial_data_pin_oe  = 1'b0;

// ----------------------------------------
// Baud generator and shifter
// ----------------------------------------
reg         strobe_level;
reg  [15:0] baud_count;
reg  [3:0]  bit_count;
reg  [8:0]  shift;
wire        master_mode;
wire        want_rx;
wire [15:0] divisor;
wire        baud_tick;
wire        fall_tick;
wire [3:0]  word_bits;
wire        word_done;

assign master_mode = serial_port_enable && transmit_status_control[`SMSR_TS_SYNC] &&
                     transmit_status_control[`SMSR_TS_STROBE_SOURCE_SELECT];
assign want_rx     = master_mode &&
                     (single_receive_enable || continuous_receive_enable);
assign divisor     = baud_control[`SMSR_BC_WIDE] ?
                     {baud_divisor_high, baud_divisor_low} :
                     {8'h00, baud_divisor_low};
assign baud_tick   = rx_active && (baud_count == 16'h0000);
assign fall_tick   = baud_tick && strobe_level;
assign word_bits   = ninth_bit_receive_enable ? 4'h9 : 4'h8;
assign word_done   = fall_tick && (bit_count == word_bits - 4'h1);

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        rx_active    <= 1'b0;
        strobe_level <= 1'b0;
        baud_count   <= 16'h0000;
        bit_count    <= 4'h0;
        shift        <= 9'h000;
    end
    else if (!rx_active)
    begin
        rx_active    <= want_rx;
        strobe_level <= 1'b0;
        baud_count   <= divisor;
        bit_count    <= 4'h0;
    end
    else if (!want_rx)
        rx_active <= 1'b0;
    else if (baud_tick)
    begin
        baud_count   <= divisor;
        strobe_level <= !strobe_level;
        if (fall_tick)
        begin
            // Strobe falls here; data settled during the high half
            shift <= {data_sync[1], shift[8:1]};
            if (word_done)
            begin
                bit_count <= 4'h0;
                // Continuous wins over single; single stops after one word
                rx_active <= continuous_receive_enable;
            end
            else
                bit_count <= bit_count + 4'h1;
        end
    end
    else
        baud_count <= baud_count - 16'h0001;
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        serial_shift_strobe_pin_out <= 1'b0;
        serial_shift_strobe_pin_oe  <= 1'b0;
    end
    else
    begin
        serial_shift_strobe_pin_out <= strobe_level ^ baud_control[`SMSR_BC_INV];
        serial_shift_strobe_pin_oe  <= master_mode;
    end
end

// ----------------------------------------
// Control writes and status
// ----------------------------------------
wire        wr_en;
wire [7:0]  wbyte;
wire [8:0]  done_word;

assign wr_en     = do_write && w_strb[0];
assign wbyte     = w_data[7:0];
assign done_word = ninth_bit_receive_enable ? {data_sync[1], shift[8:1]} :
                   {1'b0, data_sync[1], shift[8:2]};

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        interrupt_control         <= `SMSR_RST_BYTE;
        peripheral_enables_one    <= `SMSR_RST_BYTE;
        peripheral_priorities_one <= `SMSR_RST_BYTE;
        transmit_status_control   <= `SMSR_RST_BYTE;
        baud_control              <= `SMSR_RST_BYTE;
        baud_divisor_high         <= `SMSR_RST_BYTE;
        baud_divisor_low          <= `SMSR_RST_BYTE;
        receive_data_reg          <= `SMSR_RST_BYTE;
        serial_port_enable        <= 1'b0;
        ninth_bit_receive_enable  <= 1'b0;
        single_receive_enable     <= 1'b0;
        continuous_receive_enable <= 1'b0;
        framing_error_flag        <= 1'b0;
        overrun_error_flag        <= 1'b0;
        received_ninth_bit        <= 1'b0;
        receive_flag              <= 1'b0;
        irq_mask                  <= `SMSR_RST_IRQ;
    end
    else
    begin
        if (wr_en)
        begin
            case (aw_addr)
                `SMSR_OFS_INTCTL:  interrupt_control <= wbyte;
                `SMSR_OFS_PENABLE: peripheral_enables_one <= wbyte;
                `SMSR_OFS_PPRIO:   peripheral_priorities_one <= wbyte;
                `SMSR_OFS_TSTAT:   transmit_status_control <= wbyte;
                `SMSR_OFS_BAUDCTL: baud_control <= wbyte;
                `SMSR_OFS_DIVHI:   baud_divisor_high <= wbyte;
                `SMSR_OFS_DIVLO:   baud_divisor_low <= wbyte;
                `SMSR_OFS_IRQMASK: irq_mask <= wbyte[1:0];
                `SMSR_OFS_RSTAT:
                begin
                    serial_port_enable        <= wbyte[`SMSR_RS_SERIAL_PORT_ENABLE];
                    ninth_bit_receive_enable  <= wbyte[`SMSR_RS_RX9];
                    single_receive_enable     <= wbyte[`SMSR_RS_SINGLE_RECEIVE_ENABLE];
                    continuous_receive_enable <= wbyte[`SMSR_RS_CONTINUOUS_RECEIVE_ENABLE];
                    if (!wbyte[`SMSR_RS_CONTINUOUS_RECEIVE_ENABLE])
                    begin
                        framing_error_flag <= 1'b0;
                        overrun_error_flag <= 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end
        // Reading the data register frees it for the next word
        if (rdata_read)
            receive_flag <= 1'b0;
        if (word_done)
        begin
            receive_flag     <= 1'b1;
            receive_data_reg <= done_word[7:0];
            if (ninth_bit_receive_enable)
                received_ninth_bit <= done_word[8];
            // A word lost while the previous is unread: set beats clear
            if (receive_flag && !rdata_read)
                overrun_error_flag <= 1'b1;
            if (!continuous_receive_enable)
                single_receive_enable <= 1'b0;
        end
    end
end

// ----------------------------------------
// Interrupts
// ----------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
        irq_status <= `SMSR_RST_IRQ;
    else
    begin
        if (irq_read)
            irq_status <= `SMSR_RST_IRQ;
        if (word_done)
            irq_status[`SMSR_IRQ_WORD] <= 1'b1;
        if (word_done && receive_flag && !rdata_read)
            irq_status[`SMSR_IRQ_OVR] <= 1'b1;
    end
end

assign irq     = |(irq_status & irq_mask);
// Processor request follows the flag and its own enable chain
assign cpu_irq = receive_flag && peripheral_enables_one[`SMSR_PF_RXFLAG] &&
                 interrupt_control[`SMSR_INT_GIE] &&
                 interrupt_control[`SMSR_INT_PERIPHERAL_INT_ENABLE];

endmodule

/* test/smsr_receiver_chk.sv */
// Port-level assertion checker for the synchronous master receiver
`timescale 1ns/100ps
module smsr_receiver_chk
(
    input wire        aclk,
    input wire        aresetn,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        serial_data_pin_oe
);
    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_data_not_driven: assert property (!serial_data_pin_oe)
        else $error("receiver drives the data line");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered in one cycle");
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_unmapped_read: assert property (s_rd_taken ##0 (s_axi_araddr > 8'h2C)
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_unmapped_write: assert property (s_wr_taken ##0 (s_axi_awaddr > 8'h2C)
        |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'h2))
        else $error("unmapped write not refused");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule
bind smsr_receiver smsr_receiver_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .serial_data_pin_oe(serial_data_pin_oe));

/* test/smsr_slave_model.sv */
// Behavioural external slave that shifts a word out on the strobe
`timescale 1ns/100ps
module smsr_slave_model
(
    input  wire       aclk,
    input  wire       strobe,
    input  wire       strobe_oe,
    input  wire       inv,
    input  wire [3:0] nbits,
    input  wire [8:0] word,
    output logic      data
);
    logic       last;
    logic [3:0] idx;
    initial
    begin
        data = 1'h0;
        last = 1'h0;
        idx  = 4'h0;
    end
    // The bit goes out just after the rising edge and is inverted just after the falling edge, so only a fall-edge sample is right
    always @(posedge aclk)
    begin
        last <= strobe ^ inv;
        if (!strobe_oe)
        begin
            data <= ~data;
            idx  <= 4'h0;
        end
        else if ((strobe ^ inv) && !last)
        begin
            data <= word[idx];
            idx  <= (idx == nbits - 4'h1) ? 4'h0 : idx + 4'h1;
        end
        else if (!(strobe ^ inv) && last)
            data <= ~data;
    end
endmodule

/* test/tb_sync_master_serial_receiver.sv */
// Self-checking testbench for the synchronous master receiver
`timescale 1ns/100ps
module tb_sync_master_serial_receiver;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, inv;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [3:0]  nbits;
    logic [8:0]  word, val;
    logic [1:0]  rs;
    wire         awready, wready, bvalid, arready, rvalid, irq, cpu_irq, sck, sckoe, sdi;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    integer      err_count, tests_run, seed, i;
    smsr_receiver uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_data_pin_in(sdi), .serial_data_pin_out(), .serial_data_pin_oe(),
        .serial_shift_strobe_pin_in(sck), .serial_shift_strobe_pin_out(sck),
        .serial_shift_strobe_pin_oe(sckoe), .irq(irq), .cpu_irq(cpu_irq));
    smsr_slave_model partner (.aclk(aclk), .strobe(sck), .strobe_oe(sckoe), .inv(inv),
        .nbits(nbits), .word(word), .data(sdi));
    // ----------------------------------------
    // Clock, tasks and watchdog
    // ----------------------------------------
    initial
    begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end
    task chk(input [33:0] got, input [33:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("Checks %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Channels are sampled at the falling edge, where design outputs have settled
    task axi_wr(input [7:0] a, input [7:0] d, input [1:0] er);
        logic ta, tw, tb, fin;
        begin
            fin = 1'h0;
            @(posedge aclk);
            awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
            while (!fin)
            begin
                @(negedge aclk);
                ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; rs = bresp;
                @(posedge aclk);
                if (ta) awvalid <= 1'h0;
                if (tw) wvalid <= 1'h0;
                if (tb) bready <= 1'h0;
                fin = tb;
            end
            chk(rs, er);
        end
    endtask
    task axi_rd(input [7:0] a, input [31:0] ed, input [1:0] er, input [31:0] m);
        logic ta, fin;
        begin
            fin = 1'h0;
            @(posedge aclk);
            araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
            while (!fin)
            begin
                @(negedge aclk);
                ta = arvalid & arready; fin = rvalid; rd = rdata; rs = rresp;
                @(posedge aclk);
                if (ta) arvalid <= 1'h0;
                if (fin) rready <= 1'h0;
            end
            chk({rs, rd & m}, {er, ed});
        end
    endtask
    task wait_irq;
        for (i = 0; i < 2000 && irq !== 1'h1; i++) @(negedge aclk);
        chk(irq, 1'h1);
    endtask
    task strobe_quiet;
        logic p;
        begin
            p = sck;
            for (i = 0; i < 60 && sck === p; i++) @(negedge aclk);
            chk(i, 60);
        end
    endtask
    initial
    begin
        repeat (10000) @(posedge aclk);
        err_count++;
        final_report;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        seed = 40; err_count = 0; tests_run = 0; aresetn = 1'h0; inv = 1'h0; nbits = 4'h8;
        awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; word = 9'h0;
        awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0; rready = 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        for (int k = 0; k < 12; k++) axi_rd(8'(k * 4), 32'h0, 2'h0, 32'hFFFFFFBF);
        axi_rd(8'h30, 32'h0, 2'h2, 32'hFFFFFFFF);
        axi_wr(8'h31, 8'hFF, 2'h2);
        axi_wr(8'h00, 8'hC0, 2'h0);
        axi_wr(8'h08, 8'h20, 2'h0);
        axi_wr(8'h18, 8'h90, 2'h0);
        // Sampling sits three cycles behind the strobe, so keep the half period long
        axi_wr(8'h24, 8'h05, 2'h0);
        axi_wr(8'h2C, 8'h01, 2'h0);
        axi_wr(8'h10, 8'h80, 2'h0);
        @(negedge aclk);
        chk({sckoe, sck}, 2'h2);
        val = 9'($random(seed));
        word <= val;
        axi_wr(8'h10, 8'hA0, 2'h0);
        wait_irq;
        chk(cpu_irq, 1'h1);
        axi_rd(8'h10, 32'h80, 2'h0, 32'hFFFFFFFF);
        axi_rd(8'h04, 32'h20, 2'h0, 32'hFFFFFFFF);
        axi_rd(8'h14, {24'h0, val[7:0]}, 2'h0, 32'hFFFFFFFF);
        axi_rd(8'h28, 32'h1, 2'h0, 32'hFFFFFFFF);
        axi_rd(8'h28, 32'h0, 2'h0, 32'hFFFFFFFF);
        strobe_quiet;
        axi_wr(8'h10, 8'h00, 2'h0);
        inv <= 1'h1;
        nbits <= 4'h9;
        axi_wr(8'h1C, 8'h10, 2'h0);
        axi_wr(8'h24, 8'h04, 2'h0);
        axi_wr(8'h10, 8'hC0, 2'h0);
        @(negedge aclk);
        chk(sck, 1'h1);
        val = 9'($random(seed));
        word <= val;
        axi_wr(8'h10, 8'hE0, 2'h0);
        wait_irq;
        axi_rd(8'h10, {24'h0, 7'h60, val[8]}, 2'h0, 32'hFFFFFFFF);
        axi_rd(8'h14, {24'h0, val[7:0]}, 2'h0, 32'hFFFFFFFF);
        axi_rd(8'h28, 32'h1, 2'h0, 32'hFFFFFFFF);
        // Both enables set: reception must keep going
        val = 9'($random(seed));
        word <= val;
        axi_wr(8'h10, 8'hF0, 2'h0);
        repeat (2)
        begin
            wait_irq;
            axi_rd(8'h28, 32'h1, 2'h0, 32'hFFFFFFFF);
            axi_rd(8'h14, {24'h0, val[7:0]}, 2'h0, 32'hFFFFFFFF);
        end
        axi_wr(8'h2C, 8'h00, 2'h0);
        repeat (300) @(negedge aclk);
        chk(irq, 1'h0);
        axi_rd(8'h28, 32'h3, 2'h0, 32'hFFFFFFFF);
        axi_rd(8'h10, 32'h2, 2'h0, 32'h2);
        axi_wr(8'h10, 8'hC0, 2'h0);
        axi_rd(8'h10, 32'hC0, 2'h0, 32'hFFFFFFFE);
        strobe_quiet;
        final_report;
    end
endmodule
